//--- core/bsi_pkg.sv
// package: register map, field layout and timing constants of the balance scan interlock
package bsi_pkg;
  localparam int unsigned CLK_HZ         = 200_000_000;
  localparam int unsigned INHIBIT_MS     = 10;
  localparam int unsigned INHIBIT_CYCLES = CLK_HZ / 1000 * INHIBIT_MS;
  localparam int unsigned CELLS          = 12;
  localparam int unsigned EXT_INPUTS     = 4;
  localparam int unsigned ADC_W          = 14;
  localparam int unsigned INTERVAL_W     = 4;

  // register byte offsets
  localparam logic [11:0] OFF_CTRL     = 12'h000;
  localparam logic [11:0] OFF_BAL      = 12'h004;
  localparam logic [11:0] OFF_FAULTCFG = 12'h008;
  localparam logic [11:0] OFF_LIMIT    = 12'h00C;
  localparam logic [11:0] OFF_OTFAULT  = 12'h010;
  localparam logic [11:0] OFF_STATUS   = 12'h014;
  localparam logic [11:0] OFF_EXT0     = 12'h020;

  // control register fields
  localparam int unsigned CTRL_SCAN_CONT = 0;
  localparam int unsigned CTRL_BALANCE_OFF_DURING_SCAN = 1;
  localparam int unsigned CTRL_BAL_EN    = 2;
  localparam int unsigned CTRL_SLEEP     = 3;
  // fault configuration fields
  localparam int unsigned FCFG_TEST_LSB  = 0;
  localparam int unsigned FCFG_IVAL_LSB  = 8;
  // status fields
  localparam int unsigned ST_OVERTEMP_SUMMARY_FLAG = 0;
  localparam int unsigned ST_INHIBIT     = 1;
  localparam int unsigned ST_SCANNING    = 2;
  localparam int unsigned ST_BAL_ACT     = 3;

  localparam logic [31:0] RST_CTRL       = 32'h0000_0000;
  localparam logic [31:0] RST_FAULTCFG   = 32'h0000_0000;
  localparam logic [ADC_W-1:0] RST_LIMIT = 14'h0000;
  localparam logic [ADC_W-1:0] OPEN_THRESH = 14'h3C00; // 15/16 of full scale

  typedef enum logic [2:0] {
    BSI_IDLE, BSI_WAIT, BSI_INHIBIT, BSI_CELLS, BSI_REST
  } bsi_state_type;
endpackage

//--- core/bsi_scan_if.sv
// interface: scan sequencer handshake between top and timer
`timescale 1ns/10ps
interface bsi_scan_if;
  logic       start;
  logic [3:0] interval;
  logic       tick;
  modport ctl (output start, output interval, input tick);
  modport tmr (input start, input interval, output tick);
endinterface

//--- core/bsi_interval_timer.sv
// scan interval timer producing the start pulse of each scan
`timescale 1ns/10ps
module bsi_interval_timer #(
  parameter int unsigned BASE_CYCLES = 200_000
) (
  // clock and reset
  input  wire logic   core_clk,
  input  wire logic   rst_n,
  // scan control
  bsi_scan_if.tmr     scan
);
  logic [31:0] base_q;
  logic [15:0] mult_q;

  // interval n spans 2^n base periods
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      base_q <= 32'h0000_0000;
      mult_q <= 16'h0000;
      scan.tick <= 1'b0;
    end else begin
      scan.tick <= 1'b0;
      if (!scan.start) begin
        base_q <= 32'h0000_0000;
        mult_q <= 16'h0000;
      end else if (base_q >= BASE_CYCLES - 1) begin
        base_q <= 32'h0000_0000;
        if (mult_q >= (16'h0001 << scan.interval) - 16'h0001) begin
          mult_q    <= 16'h0000;
          scan.tick <= 1'b1;
        end else begin
          mult_q <= mult_q + 16'h0001;
        end
      end else begin
        base_q <= base_q + 32'h0000_0001;
      end
    end
  end
endmodule

//--- core/bsi_top.sv
// top: balance / scan interlock with thermistor fault detection, APB slave
//
// What this block does
// - balancing may stay active while continuous scanning runs, unless inhibit option set.
// - continuous mode repeats cell and temperature scans at configured interval.
// - with inhibit bit set, balancing is off 10ms before and during cell scans.
// - after an inhibited cell scan, balancing is restored unchanged.
// - pull-up switches close on all four inputs while thermistor supply is active.
// - enabled input above 15/16 full scale sets its fault bit and summary flag.
// - enabled input below the limit register also sets the same fault bits.
// - sleep or shutdown forces every balancing gate drive off.
`timescale 1ns/10ps
module bsi_top #(
  parameter int unsigned INHIBIT_CYC = bsi_pkg::INHIBIT_CYCLES,
  parameter int unsigned BASE_CYC    = 200_000,
  parameter int unsigned CELL_CYC    = 46_800,
  parameter int unsigned TEMP_CYC    = 20_000
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // power mode pin
  input  wire logic        shutdown_pin,
  // converter results for the external inputs
  input  wire logic        ext_valid,
  input  wire logic [1:0]  ext_sel,
  input  wire logic [13:0] ext_value,
  // analog control
  output logic      [11:0] bal_gate_en,
  output logic             thermistor_supply_output,
  output logic      [3:0]  pullup_en,
  output logic             cell_scan_active,
  output logic             temp_scan_active
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0]        ctrl_q;
  logic [11:0]        bal_q;
  logic [31:0]        fcfg_q;
  logic [13:0]        limit_q;
  logic [3:0]         otf_q;
  logic [13:0]        ext_q [4];
  logic               shd_s1_q, shd_s2_q;
  bsi_pkg::bsi_state_type st_q;
  logic [31:0]        cnt_q;
  logic               wr_en, rd_en;
  logic [3:0]         overtemp_set;
  logic               scan_cont, balance_off_during_scan, sleep_mode;

  bsi_scan_if scan ();

  assign scan_cont  = ctrl_q[bsi_pkg::CTRL_SCAN_CONT];
  assign balance_off_during_scan = ctrl_q[bsi_pkg::CTRL_BALANCE_OFF_DURING_SCAN];
  assign sleep_mode = ctrl_q[bsi_pkg::CTRL_SLEEP] | shd_s2_q;
  assign scan.start    = scan_cont & ~sleep_mode;
  assign scan.interval = fcfg_q[bsi_pkg::FCFG_IVAL_LSB +: 4];

  bsi_interval_timer #(.BASE_CYCLES(BASE_CYC)) u_timer (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .scan     (scan)
  );

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      shd_s1_q <= 1'b1;
      shd_s2_q <= 1'b1;
    end else begin
      shd_s1_q <= shutdown_pin;
      shd_s2_q <= shd_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  function automatic logic addr_ok(input logic [11:0] a);
    addr_ok = (a == bsi_pkg::OFF_CTRL) || (a == bsi_pkg::OFF_BAL) ||
              (a == bsi_pkg::OFF_FAULTCFG) || (a == bsi_pkg::OFF_LIMIT) ||
              (a == bsi_pkg::OFF_OTFAULT) || (a == bsi_pkg::OFF_STATUS) ||
              (a[11:4] == bsi_pkg::OFF_EXT0[11:4] && a[1:0] == 2'b00);
  endfunction

  assign pready  = 1'b1;
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & ~penable & ~pwrite;
  assign pslverr = psel & penable & ~addr_ok(paddr);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q  <= bsi_pkg::RST_CTRL;
      bal_q   <= 12'h000;
      fcfg_q  <= bsi_pkg::RST_FAULTCFG;
      limit_q <= bsi_pkg::RST_LIMIT;
    end else if (wr_en) begin
      if (paddr == bsi_pkg::OFF_CTRL) begin
        ctrl_q <= {28'h000_0000, pwdata[3:0]};
      end else if (paddr == bsi_pkg::OFF_BAL) begin
        bal_q <= pwdata[11:0];
      end else if (paddr == bsi_pkg::OFF_FAULTCFG) begin
        fcfg_q <= {20'h0_0000, pwdata[11:8], 4'h0, pwdata[3:0]};
      end else if (paddr == bsi_pkg::OFF_LIMIT) begin
        limit_q <= pwdata[13:0];
      end
    end
  end

  // reads prepared at setup, held in the access phase
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      if (paddr == bsi_pkg::OFF_CTRL) begin
        prdata <= ctrl_q;
      end else if (paddr == bsi_pkg::OFF_BAL) begin
        prdata <= {20'h0_0000, bal_q};
      end else if (paddr == bsi_pkg::OFF_FAULTCFG) begin
        prdata <= fcfg_q;
      end else if (paddr == bsi_pkg::OFF_LIMIT) begin
        prdata <= {18'h0_0000, limit_q};
      end else if (paddr == bsi_pkg::OFF_OTFAULT) begin
        prdata <= {28'h000_0000, otf_q};
      end else if (paddr == bsi_pkg::OFF_STATUS) begin
        prdata <= {28'h000_0000, |bal_gate_en, cell_scan_active | temp_scan_active,
                   st_q == bsi_pkg::BSI_INHIBIT ||
                   (balance_off_during_scan && st_q == bsi_pkg::BSI_CELLS),
                   |otf_q};
      end else if (addr_ok(paddr)) begin
        prdata <= {18'h0_0000, ext_q[paddr[3:2]]};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // scan sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q  <= bsi_pkg::BSI_IDLE;
      cnt_q <= 32'h0000_0000;
    end else if (!scan.start) begin
      st_q  <= bsi_pkg::BSI_IDLE;
      cnt_q <= 32'h0000_0000;
    end else begin
      case (st_q)
        bsi_pkg::BSI_IDLE: begin
          st_q <= bsi_pkg::BSI_WAIT;
        end
        bsi_pkg::BSI_WAIT: begin
          cnt_q <= 32'h0000_0000;
          if (scan.tick) begin
            st_q <= balance_off_during_scan ? bsi_pkg::BSI_INHIBIT
                                            : bsi_pkg::BSI_CELLS;
          end
        end
        bsi_pkg::BSI_INHIBIT: begin
          // gives the balance devices time to turn off before measuring
          if (cnt_q >= INHIBIT_CYC - 1) begin
            cnt_q <= 32'h0000_0000;
            st_q  <= bsi_pkg::BSI_CELLS;
          end else begin
            cnt_q <= cnt_q + 32'h0000_0001;
          end
        end
        bsi_pkg::BSI_CELLS: begin
          if (cnt_q >= CELL_CYC - 1) begin
            cnt_q <= 32'h0000_0000;
            st_q  <= bsi_pkg::BSI_REST;
          end else begin
            cnt_q <= cnt_q + 32'h0000_0001;
          end
        end
        bsi_pkg::BSI_REST: begin
          if (cnt_q >= TEMP_CYC - 1) begin
            cnt_q <= 32'h0000_0000;
            st_q  <= bsi_pkg::BSI_WAIT;
          end else begin
            cnt_q <= cnt_q + 32'h0000_0001;
          end
        end
        default: begin
          st_q <= bsi_pkg::BSI_IDLE;
        end
      endcase
    end
  end

  assign cell_scan_active = (st_q == bsi_pkg::BSI_CELLS);
  assign temp_scan_active = (st_q == bsi_pkg::BSI_REST);

  // ----------------------------------------------------------------
  // balancing gate drive
  // ----------------------------------------------------------------
  // bal_q is never touched by the interlock, so pattern resumes as it was
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bal_gate_en <= 12'h000;
    end else if (sleep_mode || !ctrl_q[bsi_pkg::CTRL_BAL_EN]) begin
      bal_gate_en <= 12'h000;
    end else if (balance_off_during_scan &&
                 (st_q == bsi_pkg::BSI_INHIBIT || st_q == bsi_pkg::BSI_CELLS)) begin
      bal_gate_en <= 12'h000;
    end else begin
      bal_gate_en <= bal_q;
    end
  end

  // ----------------------------------------------------------------
  // external inputs and over-temperature faults
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      thermistor_supply_output <= 1'b0;
      pullup_en                <= 4'h0;
    end else begin
      thermistor_supply_output <= ~sleep_mode;
      pullup_en                <= {4{thermistor_supply_output}};
    end
  end

  always_comb begin
    overtemp_set = 4'h0;
    if (ext_valid && fcfg_q[bsi_pkg::FCFG_TEST_LSB + ext_sel] &&
        (ext_value > bsi_pkg::OPEN_THRESH || ext_value < limit_q)) begin
      overtemp_set[ext_sel] = 1'b1;
    end
  end

  // fault bits clear on write of ones; a new event wins over the clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      otf_q <= 4'h0;
    end else if (wr_en && paddr == bsi_pkg::OFF_OTFAULT) begin
      otf_q <= (otf_q & ~pwdata[3:0]) | overtemp_set;
    end else begin
      otf_q <= otf_q | overtemp_set;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_q <= '{default: 14'h0000};
    end else if (ext_valid) begin
      ext_q[ext_sel] <= ext_value;
    end
  end
endmodule

//--- tb/bsi_host.sv
// apb host model for the register port
`timescale 1ns/10ps
module bsi_host (
  // clock
  input  wire logic        core_clk,
  // apb master
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d; // released bus must not show stale data
  endtask
endmodule

//--- tb/bsi_chk.sv
// checker: properties on the top module ports
`timescale 1ns/10ps
module bsi_chk (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst_n,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // pins
  input wire logic        shutdown_pin,
  input wire logic [11:0] bal_gate_en,
  input wire logic        thermistor_supply_output,
  input wire logic [3:0]  pullup_en,
  input wire logic        cell_scan_active,
  input wire logic        temp_scan_active
);
  logic [3:0]  ctrl_q;
  logic [11:0] bal_q;
  // shadow of programmed control, so gate checks know the intended state
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= 4'h0;
      bal_q  <= 12'h000;
    end else if (psel && penable && pwrite) begin
      if (paddr == bsi_pkg::OFF_CTRL) ctrl_q <= pwdata[3:0];
      if (paddr == bsi_pkg::OFF_BAL) bal_q <= pwdata[11:0];
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_rdy; psel && penable |-> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready low in access");
  property p_err; psel && penable |-> pslverr == !((paddr inside {[12'h000:12'h014],
    [12'h020:12'h02C]}) && paddr[1:0] == 2'b00); endproperty
  a_err: assert property (p_err) else $error("pslverr wrong for address");
  property p_pull; pullup_en == {4{$past(thermistor_supply_output)}}; endproperty
  a_pull: assert property (p_pull) else $error("pull-ups do not follow supply");
  // 40 cycles cover tick-to-end-of-cells, since the option is taken at the tick
  property p_inh; ctrl_q[1] && $past(ctrl_q[1], 40) && cell_scan_active
    |=> bal_gate_en == 12'h000; endproperty
  a_inh: assert property (p_inh) else $error("gates on during cell scan");
  property p_free; !ctrl_q[1] && !$past(ctrl_q[1], 40) && ctrl_q[2] && !ctrl_q[3]
    && !shutdown_pin && cell_scan_active |=> bal_gate_en == $past(bal_q); endproperty
  a_free: assert property (p_free) else $error("scan disturbed balancing");
  property p_slp; ctrl_q[3] |=> bal_gate_en == 12'h000; endproperty
  a_slp: assert property (p_slp) else $error("gates on in sleep");
  property p_sd; shutdown_pin [*4] |=> bal_gate_en == 12'h000; endproperty
  a_sd: assert property (p_sd) else $error("gates on in shutdown");
  property p_seq; $rose(cell_scan_active) |-> ##[1:20] temp_scan_active; endproperty
  a_seq: assert property (p_seq) else $error("no temperature scan after cells");
  property p_rep; ctrl_q[0] && !ctrl_q[3] && $fell(temp_scan_active)
    |-> ##[1:60] (cell_scan_active || !ctrl_q[0]); endproperty
  a_rep: assert property (p_rep) else $error("continuous scan not repeated");
endmodule

//--- tb/bsi_top_tb.sv
// testbench: registers, external input faults and balance interlock
`timescale 1ns/10ps
bind bsi_top bsi_chk chk_u (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .pslverr, .shutdown_pin, .bal_gate_en, .thermistor_supply_output, .pullup_en,
  .cell_scan_active, .temp_scan_active);
module bsi_top_tb;
  logic        core_clk = 1'b0, rst_n = 1'b0, shutdown_pin = 1'b0, ext_valid = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, thermistor_supply_output;
  logic        cell_scan_active, temp_scan_active;
  logic [1:0]  ext_sel = 2'h0;
  logic [13:0] ext_value = 14'h0000, lim, v, last [4];
  logic [11:0] paddr, bal_gate_en, bal;
  logic [31:0] pwdata, prdata, r;
  logic [3:0]  pullup_en, en, fexp;
  int          n_errors = 0, num_checks = 0, k, z;
  always #2.5 core_clk = ~core_clk;
  bsi_top #(.INHIBIT_CYC(20), .BASE_CYC(10), .CELL_CYC(8), .TEMP_CYC(6)) dut_u (
    .core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .shutdown_pin, .ext_valid, .ext_sel, .ext_value, .bal_gate_en,
    .thermistor_supply_output, .pullup_en, .cell_scan_active, .temp_scan_active);
  bsi_host host_u (.core_clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready);
  function automatic logic hot(input logic e, input logic [13:0] x, input logic [13:0] l);
    return e && (x > 14'h3C00 || x < l);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host_u.xfer(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    host_u.xfer(1'b0, a, 32'h0000_0000, r);
    chk(r, e);
  endtask
  task automatic ext(input logic [1:0] s, input logic [13:0] x);
    @(posedge core_clk);
    ext_valid <= 1'b1;
    ext_sel <= s;
    ext_value <= x;
    @(posedge core_clk);
    ext_valid <= 1'b0;
    ext_value <= ~x;
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #100_000;
    n_errors++;
    final_report;
  end
  // ----------
  // scenarios
  // ----------
  initial begin
    void'($urandom(32'hfb53));
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(bsi_pkg::OFF_CTRL, bsi_pkg::RST_CTRL);
    rd(bsi_pkg::OFF_FAULTCFG, bsi_pkg::RST_FAULTCFG);
    rd(bsi_pkg::OFF_LIMIT, {18'h0, bsi_pkg::RST_LIMIT});
    rd(12'h018, 32'h0000_0000);
    // input 1 left off so the enable is seen to gate the flag
    en = {1'($urandom()), 3'b101};
    lim = 14'($urandom()) & 14'h1FFF;
    wr(bsi_pkg::OFF_FAULTCFG, {20'h0, 4'h1, 4'hF, en});
    rd(bsi_pkg::OFF_FAULTCFG, {20'h0, 4'h1, 4'h0, en});
    wr(bsi_pkg::OFF_LIMIT, {18'h0, lim});
    fexp = 4'h0;
    for (k = 0; k < 16; k++) begin
      case (k)
        0: v = 14'h3C00;
        1: v = 14'h3C01;
        2: v = lim;
        3: v = lim - 14'h0001;
        6: v = 14'h3FFF;
        default: v = 14'($urandom());
      endcase
      ext(2'(k), v);
      last[k % 4] = v;
      fexp[k % 4] = fexp[k % 4] | hot(en[k % 4], v, lim);
    end
    rd(bsi_pkg::OFF_OTFAULT, {28'h0, fexp});
    rd(bsi_pkg::OFF_STATUS, {31'h0, |fexp});
    for (k = 0; k < 4; k++) rd(bsi_pkg::OFF_EXT0 + 12'(4 * k), {18'h0, last[k]});
    wr(bsi_pkg::OFF_OTFAULT, 32'h0000_000F);
    rd(bsi_pkg::OFF_OTFAULT, 32'h0000_0000);
    bal = 12'($urandom()) | 12'h001;
    wr(bsi_pkg::OFF_BAL, {20'h0, bal});
    wr(bsi_pkg::OFF_CTRL, 32'h0000_0005);
    repeat (2) @(negedge core_clk);
    z = 0;
    repeat (200) @(negedge core_clk) if (bal_gate_en !== bal) z++;
    chk(32'(z), 32'h0000_0000);
    chk({28'h0, pullup_en}, 32'h0000_000F);
    wr(bsi_pkg::OFF_CTRL, 32'h0000_0007);
    repeat (2) begin
      while (cell_scan_active !== 1'b0) @(negedge core_clk);
      z = 0;
      while (cell_scan_active !== 1'b1) begin
        @(negedge core_clk);
        z = (bal_gate_en === 12'h000) ? z + 1 : 0;
      end
    end
    chk(32'(z >= 20), 32'h0000_0001);
    while (temp_scan_active !== 1'b1) @(negedge core_clk);
    @(negedge core_clk);
    chk({20'h0, bal_gate_en}, {20'h0, bal});
    wr(bsi_pkg::OFF_CTRL, 32'h0000_000F);
    repeat (2) @(negedge core_clk);
    chk({20'h0, bal_gate_en}, 32'h0000_0000);
    wr(bsi_pkg::OFF_CTRL, 32'h0000_0004);
    repeat (40) @(posedge core_clk);
    shutdown_pin <= 1'b1;
    repeat (6) @(negedge core_clk);
    chk({20'h0, bal_gate_en}, 32'h0000_0000);
    chk({28'h0, pullup_en}, 32'h0000_0000);
    final_report;
  end
endmodule
